// file: dv/fwpg_gate_asserts.sv
// port-level checks of the write-protect gate
`timescale 1ns/100ps
module fwpg_gate_asserts (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       link_cs_b,
  input wire logic       reg_wr,
  input wire logic       cmd_accept,
  input wire logic       cmd_reject,
  input wire logic [7:0] cmd_opcode,
  input wire logic       write_enable_latch,
  input wire logic       deep_sleep_state
);
  logic [11:0] up_cnt_r;
  wire         wr_stat;
  assign wr_stat = cmd_opcode == fwpg_pkg::OP_WRSR1 ||
                   cmd_opcode == fwpg_pkg::OP_WRSR2;

  // ----------------------------------------
  // cycles since supply reset went away
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt_r <= 12'h000;
    end else if (up_cnt_r != 12'hFFF) begin
      up_cnt_r <= up_cnt_r + 12'h001;
    end
  end

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  quiet_reset_a: assert property (disable iff (1'b0)
    !rst_b && !$past(rst_b) |-> !cmd_accept && !write_enable_latch)
    else $error("output active in reset");
  puw_lock_a: assert property (
    $rose(write_enable_latch) |-> up_cnt_r >= fwpg_pkg::PUW_LAST)
    else $error("latch set in lockout");
  latch_set_a: assert property (
    $rose(write_enable_latch) |-> link_cs_b && $past(link_cs_b, 3))
    else $error("latch set without frame");
  need_latch_a: assert property (
    cmd_accept |-> $past(write_enable_latch))
    else $error("accept without latch");
  stat_clear_a: assert property (
    cmd_accept && wr_stat |-> !write_enable_latch)
    else $error("latch kept after status write");
  latch_drop_a: assert property (
    $fell(write_enable_latch) |-> $past(link_cs_b, 2) || $past(reg_wr))
    else $error("latch dropped without cause");
  one_verdict_a: assert property (
    cmd_accept |-> !cmd_reject)
    else $error("accept and reject together");
  frame_end_a: assert property (
    cmd_accept || cmd_reject |-> link_cs_b && $past(link_cs_b, 2))
    else $error("verdict inside frame");
  sleep_quiet_a: assert property (
    deep_sleep_state && $past(deep_sleep_state) |-> !cmd_accept)
    else $error("accept in deep sleep");

  cover property (cmd_accept);
  cover property (cmd_reject);
  cover property ($rose(deep_sleep_state));
  cover property ($fell(write_enable_latch) && $past(reg_wr));
endmodule : fwpg_gate_asserts

bind fwpg_gate fwpg_gate_asserts fwpg_gate_asserts_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .link_cs_b(link_cs_b),
  .reg_wr(reg_wr), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
  .cmd_opcode(cmd_opcode), .write_enable_latch(write_enable_latch),
  .deep_sleep_state(deep_sleep_state));

// file: dv/fwpg_spi_host.sv
// serial host model issuing flash command frames
`timescale 1ns/100ps
module fwpg_spi_host (
  output logic link_sclk,
  output logic link_cs_b,
  output logic link_di
);
  initial begin
    link_sclk = 1'b0;
    link_cs_b = 1'b1;
    link_di   = 1'b0;
  end

  // mode 0 frame, msb first, first nb bits of d
  task automatic send(input logic [39:0] d, input int nb);
    link_cs_b <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      link_di <= d[39-i];
      #24 link_sclk <= 1'b1;
      #24 link_sclk <= 1'b0;
    end
    #24 link_cs_b <= 1'b1;
    link_di <= ~link_di;
    #100;
  endtask : send
endmodule : fwpg_spi_host

// file: dv/testbench.sv
// self-checking bench for the flash write-protect gate
`timescale 1ns/100ps
module testbench;
  logic        sys_clk   = 1'b0;
  logic        rst_b     = 1'b1;
  logic        clk_en    = 1'b1;
  logic        wp_b      = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  opc;
  logic [23:0] adr;
  logic        acc;
  logic        rej;
  logic        wen;
  logic        slp;
  logic        sclk;
  logic        cs_b;
  logic        di;
  int          num_errors = 0;
  int          n_tests    = 0;
  int          n_acc;
  int          n_rej;

  always #2.5 sys_clk = ~sys_clk;

  fwpg_gate fwpg_gate_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .link_sclk(sclk), .link_cs_b(cs_b), .link_di(di), .wp_b(wp_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .cmd_accept(acc),
    .cmd_reject(rej), .cmd_opcode(opc), .cmd_addr(adr),
    .write_enable_latch(wen), .deep_sleep_state(slp));
  fwpg_spi_host fwpg_spi_host_i (.link_sclk(sclk), .link_cs_b(cs_b),
    .link_di(di));

  always @(posedge sys_clk) begin
    if (acc === 1'b1) n_acc++;
    if (rej === 1'b1) n_rej++;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rd

  // er below zero leaves the reject count unjudged
  task automatic frame(input logic [39:0] d, input int nb, ea, er);
    n_acc = 0;
    n_rej = 0;
    fwpg_spi_host_i.send(d, nb);
    chk("accept", ea, n_acc);
    if (er >= 0) chk("reject", er, n_rej);
  endtask : frame

  task automatic wren;
    frame({fwpg_pkg::OP_WREN, 32'h0}, 8, 0, 0);
  endtask : wren

  task automatic wrsr(input logic [7:0] s1, s2, input int ea);
    wren();
    frame({fwpg_pkg::OP_WRSR1, s1, s2, 16'h0}, 24, ea, 1 - ea);
  endtask : wrsr

  task automatic op(input logic [7:0] o, input logic [23:0] a, int ea);
    int nb;
    nb = (o == fwpg_pkg::OP_PP || o == fwpg_pkg::OP_QPP) ? 40 : 32;
    if (o == fwpg_pkg::OP_CE_A || o == fwpg_pkg::OP_CE_B) nb = 8;
    wren();
    frame({o, a, 8'h00}, nb, ea, 1 - ea);
    if (ea == 1) begin
      chk("opcode", o, opc);
      chk("addr", a, adr);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= fwpg_pkg::REG_CTRL;
      reg_wdata <= 8'h01;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
      #1 chk("latch", 0, wen);
    end
  endtask : op

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_powerup;
    rd(fwpg_pkg::REG_SR1, 8'h00);
    rd(fwpg_pkg::REG_SR2, 8'h00);
    rd(fwpg_pkg::REG_STATE, 8'h02);
    rd(4'h2, 8'h00);
    frame({fwpg_pkg::OP_WREN, 32'h0}, 8, 0, 1);
    chk("latch", 0, wen);
    repeat (fwpg_pkg::PUW_CYCLES) @(posedge sys_clk);
  endtask : t_powerup

  task automatic t_latch;
    frame({fwpg_pkg::OP_SE, 32'h0}, 32, 0, 1);
    wren();
    chk("latch", 1, wen);
    frame({fwpg_pkg::OP_SE, 32'h0}, 31, 0, 1);
    frame({fwpg_pkg::OP_WRDI, 32'h0}, 8, 0, 0);
    chk("latch", 0, wen);
    // frozen gate must not see a write enable frame
    @(posedge sys_clk);
    clk_en <= 1'b0;
    frame({fwpg_pkg::OP_WREN, 32'h0}, 8, 0, 0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    chk("latch", 0, wen);
    op(fwpg_pkg::OP_SE, 24'h012345, 1);
    op(fwpg_pkg::OP_PP, 24'h0ABC00, 1);
    op(fwpg_pkg::OP_QPP, 24'h0ABD00, 1);
  endtask : t_latch

  task automatic t_protect;
    logic [48:0] tb[13] = '{
      {8'h04, 8'h00, fwpg_pkg::OP_SE,   24'h0F0000, 1'b0},
      {8'h04, 8'h00, fwpg_pkg::OP_SE,   24'h0EF000, 1'b1},
      {8'h24, 8'h00, fwpg_pkg::OP_BE64, 24'h000000, 1'b0},
      {8'h24, 8'h00, fwpg_pkg::OP_BE32, 24'h010000, 1'b1},
      {8'h44, 8'h00, fwpg_pkg::OP_SE,   24'h0FF000, 1'b0},
      {8'h44, 8'h00, fwpg_pkg::OP_SE,   24'h0FE000, 1'b1},
      {8'h70, 8'h00, fwpg_pkg::OP_BE32, 24'h000000, 1'b0},
      {8'h70, 8'h00, fwpg_pkg::OP_SE,   24'h008000, 1'b1},
      {8'h14, 8'h00, fwpg_pkg::OP_CE_B, 24'h000000, 1'b0},
      {8'h58, 8'h00, fwpg_pkg::OP_SE,   24'h000000, 1'b0},
      {8'h04, 8'h40, fwpg_pkg::OP_SE,   24'h0F0000, 1'b1},
      {8'h04, 8'h40, fwpg_pkg::OP_PP,   24'h0EFF00, 1'b0},
      {8'h00, 8'h00, fwpg_pkg::OP_CE_A, 24'h000000, 1'b1}};
    foreach (tb[i]) begin
      wrsr(tb[i][48:41], tb[i][40:33], 1);
      rd(fwpg_pkg::REG_SR1, tb[i][48:41]);
      rd(fwpg_pkg::REG_SR2, tb[i][40:33]);
      op(tb[i][32:25], tb[i][24:1], tb[i][0]);
    end
  endtask : t_protect

  task automatic t_sleep;
    frame({fwpg_pkg::OP_SLEEP, 32'h0}, 8, 0, 0);
    chk("sleep", 1, slp);
    frame({fwpg_pkg::OP_WREN, 32'h0}, 8, 0, 1);
    chk("latch", 0, wen);
    frame({fwpg_pkg::OP_WAKE, 32'h0}, 8, 0, 0);
    chk("sleep", 0, slp);
  endtask : t_sleep

  task automatic t_modes;
    wrsr(8'h80, 8'h00, 1);
    wp_b <= 1'b0;
    wrsr(8'h00, 8'h00, 0);
    wp_b <= 1'b1;
    wrsr(8'h00, 8'h00, 1);
    wren();
    frame({fwpg_pkg::OP_WRSR2, 8'h01, 24'h0}, 16, 1, 0);
    wrsr(8'h00, 8'h00, 0);
    frame({fwpg_pkg::OP_RSTEN, 32'h0}, 8, 0, 0);
    frame({fwpg_pkg::OP_RST, 32'h0}, 8, 0, 0);
    rd(fwpg_pkg::REG_SR2, 8'h00);
    wrsr(8'h80, 8'h01, 1);
    frame({fwpg_pkg::OP_RSTEN, 32'h0}, 8, 0, 0);
    frame({fwpg_pkg::OP_RST, 32'h0}, 8, 0, 0);
    wrsr(8'h00, 8'h00, 0);
  endtask : t_modes

  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  initial begin
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("latch", 0, wen);
    chk("sleep", 0, slp);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_powerup();
    t_latch();
    t_protect();
    t_sleep();
    t_modes();
    conclude();
  end

  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule : testbench

// file: src/fwpg_gate.sv
// write-protection gate of a serial flash, sampling the serial link
`timescale 1ns/100ps

// Function
// - while supply reset is low, nothing operates and no command is seen
// - after reset, write-class commands and write enable wait out a delay
// - write enable latch is cleared at power-up
// - write-class commands need the write enable latch set first
// - completion of program, erase or status write clears the latch
// - write-class commands ending mid-byte are ignored
// - in deep sleep only the wake command is honoured
// - program or erase touching any protected address is ignored
// - block codes 001-100 protect 1,2,4,8 blocks, top or bottom
// - sector codes protect 4,8,16,32 kB at top or bottom
// - codes 11x, or 101 with blocks, protect the whole array
// - complement bit swaps protected and unprotected regions
// - status write command updates granularity, side and code bits
// - write-protect pin can lock status writes per protect mode
// - lock-down mode blocks status writes until reset
// - one-time mode blocks status writes until supply reset
// - mode 00 free, 01 pin-gated, 10 locked, 11 permanent
// - lock-down mode returns to 00 on power-up or soft reset
// - granularity bit sits in status 1 bit 6, default block
// - complement bit sits in status 2 bit 6, default clear
module fwpg_gate (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        link_sclk,
  input  wire logic        link_cs_b,
  input  wire logic        link_di,
  input  wire logic        wp_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             cmd_accept,
  output logic             cmd_reject,
  output logic      [7:0]  cmd_opcode,
  output logic      [23:0] cmd_addr,
  output logic             write_enable_latch,
  output logic             deep_sleep_state
);

  // ----------------------------------------------------------------
  // command classes
  // ----------------------------------------------------------------
  function automatic logic is_arr_op(input logic [7:0] op);
    is_arr_op = (op == fwpg_pkg::OP_PP)   | (op == fwpg_pkg::OP_QPP) |
                (op == fwpg_pkg::OP_SE)   | (op == fwpg_pkg::OP_BE32) |
                (op == fwpg_pkg::OP_BE64) | (op == fwpg_pkg::OP_CE_A) |
                (op == fwpg_pkg::OP_CE_B);
  endfunction : is_arr_op

  function automatic logic is_sr_op(input logic [7:0] op);
    is_sr_op = (op == fwpg_pkg::OP_WRSR1) | (op == fwpg_pkg::OP_WRSR2);
  endfunction : is_sr_op

  // least byte count a write-class frame needs
  function automatic logic [2:0] min_bytes(input logic [7:0] op);
    if ((op == fwpg_pkg::OP_PP) | (op == fwpg_pkg::OP_QPP)) begin
      min_bytes = 3'h5;
    end else if (is_sr_op(op)) begin
      min_bytes = 3'h2;
    end else if ((op == fwpg_pkg::OP_CE_A) | (op == fwpg_pkg::OP_CE_B)) begin
      min_bytes = 3'h1;
    end else begin
      min_bytes = 3'h4;
    end
  endfunction : min_bytes

  // span mask of the target region
  function automatic logic [19:0] span_mask(input logic [7:0] op);
    case (op)
      fwpg_pkg::OP_PP,
      fwpg_pkg::OP_QPP:  span_mask = 20'h000FF;
      fwpg_pkg::OP_SE:   span_mask = 20'h00FFF;
      fwpg_pkg::OP_BE32: span_mask = 20'h07FFF;
      fwpg_pkg::OP_BE64: span_mask = 20'h0FFFF;
      default:           span_mask = 20'hFFFFF;
    endcase
  endfunction : span_mask

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_m_r;
  logic sys_rst_b_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r     <= 1'b0;
      sys_rst_b_r <= 1'b0;
    end else if (clk_en) begin
      rst_m_r     <= 1'b1;
      sys_rst_b_r <= rst_m_r;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers: 0 sclk, 1 cs, 2 di, 3 wp
  // ----------------------------------------------------------------
  logic [3:0] pin_m_r;
  logic [3:0] pin_s_r;
  logic       sclk_d_r;
  logic       cs_d_r;

  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      pin_m_r  <= 4'hF;
      pin_s_r  <= 4'hF;
      sclk_d_r <= 1'b1;
      cs_d_r   <= 1'b1;
    end else if (clk_en) begin
      pin_m_r  <= {wp_b, link_di, link_cs_b, link_sclk};
      pin_s_r  <= pin_m_r;
      sclk_d_r <= pin_s_r[0];
      cs_d_r   <= pin_s_r[1];
    end
  end

  wire sclk_rise = pin_s_r[0] & ~sclk_d_r;
  wire cs_rise   = pin_s_r[1] & ~cs_d_r;
  wire cs_fall   = ~pin_s_r[1] & cs_d_r;
  wire wp_high   = pin_s_r[3];

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  fwpg_pkg::fwpg_frame_t state_r;
  fwpg_pkg::fwpg_frame_t state_nxt;
  logic [2:0]  bit_cnt_r;
  logic [2:0]  byte_cnt_r;
  logic [6:0]  shift_r;
  logic [7:0]  op_r;
  logic [23:0] addr_r;
  logic [7:0]  dat1_r;
  logic [7:0]  dat2_r;

  always_comb begin
    case (state_r)
      fwpg_pkg::FR_IDLE:
        state_nxt = cs_fall ? fwpg_pkg::FR_SHIFT : fwpg_pkg::FR_IDLE;
      fwpg_pkg::FR_SHIFT:
        state_nxt = cs_rise ? fwpg_pkg::FR_EVAL : fwpg_pkg::FR_SHIFT;
      fwpg_pkg::FR_EVAL:
        state_nxt = cs_fall ? fwpg_pkg::FR_SHIFT : fwpg_pkg::FR_IDLE;
      default:
        state_nxt = fwpg_pkg::FR_IDLE;
    endcase
  end

  wire       shifting = (state_r == fwpg_pkg::FR_SHIFT) & sclk_rise;
  wire       start_w  = (state_nxt == fwpg_pkg::FR_SHIFT) &
                        (state_r != fwpg_pkg::FR_SHIFT);
  wire       byte_end = shifting & (bit_cnt_r == 3'h7);
  wire [7:0] byte_w   = {shift_r, pin_s_r[2]};
  wire [2:0] byte_inc = (byte_cnt_r == 3'h7) ? byte_cnt_r
                                             : 3'(byte_cnt_r + 3'h1);

  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      state_r <= fwpg_pkg::FR_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 3'h0;
      shift_r    <= 7'h00;
    end else if (clk_en) begin
      if (start_w) begin
        bit_cnt_r  <= 3'h0;
        byte_cnt_r <= 3'h0;
      end else if (shifting) begin
        bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
        shift_r   <= byte_w[6:0];
        if (byte_end) begin
          byte_cnt_r <= byte_inc;
        end
      end
    end
  end

  // bytes land in fixed slots by position in the frame
  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      op_r   <= 8'h00;
      addr_r <= 24'h000000;
      dat1_r <= 8'h00;
      dat2_r <= 8'h00;
    end else if (clk_en && byte_end) begin
      case (byte_cnt_r)
        3'h0:    op_r          <= byte_w;
        3'h1:    addr_r[23:16] <= byte_w;
        3'h2:    addr_r[15:8]  <= byte_w;
        3'h3:    addr_r[7:0]   <= byte_w;
        default: ;
      endcase
      if (byte_cnt_r == 3'h1) begin
        dat1_r <= byte_w;
      end
      if (byte_cnt_r == 3'h2) begin
        dat2_r <= byte_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // protection state
  // ----------------------------------------------------------------
  logic       sec_r;
  logic       tb_r;
  logic [2:0] bp_r;
  logic       cmp_r;
  logic [1:0] mode_r;
  logic       wen_r;
  logic       sleep_r;
  logic       busy_r;
  logic       arm_r;
  logic       rej_r;
  logic [11:0] puw_cnt_r;

  fwpg_prot_if prot ();

  assign prot.sec    = sec_r;
  assign prot.tb     = tb_r;
  assign prot.cmp    = cmp_r;
  assign prot.bp     = bp_r;
  assign prot.tgt_lo = addr_r[19:0] & ~span_mask(op_r);
  assign prot.tgt_hi = addr_r[19:0] | span_mask(op_r);

  fwpg_range_dec u_dec (
    .p (prot.dec)
  );

  // ----------------------------------------------------------------
  // verdict on frame end
  // ----------------------------------------------------------------
  wire eval_w   = (state_r == fwpg_pkg::FR_EVAL);
  wire live_w   = eval_w & ~sleep_r & ~busy_r;
  wire whole_w  = (bit_cnt_r == 3'h0) & (byte_cnt_r != 3'h0);
  wire enough_w = byte_cnt_r >= min_bytes(op_r);
  wire puw_w    = (puw_cnt_r != fwpg_pkg::PUW_LAST);
  wire arr_w    = is_arr_op(op_r);
  wire srw_w    = is_sr_op(op_r);
  wire wren_w   = (op_r == fwpg_pkg::OP_WREN);

  // write-class gate: whole bytes, lockout over, latch set
  wire write_ok = live_w & whole_w & enough_w & ~puw_w &
                  wen_r;
  wire arr_ok   = write_ok & arr_w & ~prot.hit;
  // protect mode: pin gates 01, 10 and 11 block
  wire sr_open  = (mode_r == fwpg_pkg::MODE_SW) |
                  ((mode_r == fwpg_pkg::MODE_HW) & wp_high);
  wire sr_ok    = write_ok & srw_w & sr_open;
  wire wen_set  = live_w & whole_w & wren_w & ~puw_w;
  wire wen_off  = live_w & whole_w & (op_r == fwpg_pkg::OP_WRDI);
  wire soft_rst = live_w & whole_w & arm_r &
                  (op_r == fwpg_pkg::OP_RST);
  wire done_w   = reg_wr & (reg_addr == fwpg_pkg::REG_CTRL) &
                  reg_wdata[fwpg_pkg::CTRL_DONE] & busy_r;
  wire rej_w    = eval_w & (arr_w | srw_w | wren_w) &
                  ~(arr_ok | sr_ok | wen_set);
  wire sr1_two  = (op_r == fwpg_pkg::OP_WRSR1) & (byte_cnt_r > 3'h2);
  wire [7:0] sr2_byte = (op_r == fwpg_pkg::OP_WRSR2) ? dat1_r : dat2_r;
  wire sr1_wr   = sr_ok & (op_r == fwpg_pkg::OP_WRSR1);
  wire sr2_wr   = sr_ok & ((op_r == fwpg_pkg::OP_WRSR2) | sr1_two);

  // latch: set or clear by command, cleared when an operation ends
  wire wen_nxt  = wen_set ? 1'b1 :
                  (wen_off | sr_ok | soft_rst | done_w) ? 1'b0 :
                  wen_r;
  wire wake_w   = eval_w & sleep_r & (byte_cnt_r != 3'h0) &
                  (op_r == fwpg_pkg::OP_WAKE);
  wire nap_w    = live_w & whole_w & (op_r == fwpg_pkg::OP_SLEEP);
  wire arm_nxt  = live_w ? (whole_w & (op_r == fwpg_pkg::OP_RSTEN))
                         : arm_r;

  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      wen_r   <= 1'b0;
      sleep_r <= 1'b0;
      busy_r  <= 1'b0;
      arm_r   <= 1'b0;
      rej_r   <= 1'b0;
    end else if (clk_en) begin
      wen_r   <= wen_nxt;
      sleep_r <= nap_w | (sleep_r & ~wake_w);
      busy_r  <= arr_ok | (busy_r & ~done_w);
      arm_r   <= arm_nxt;
      rej_r   <= eval_w ? rej_w : rej_r;
    end
  end

  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      puw_cnt_r <= 12'h000;
    end else if (clk_en && puw_w) begin
      puw_cnt_r <= 12'(puw_cnt_r + 12'h001);
    end
  end

  // ----------------------------------------------------------------
  // status fields written by the status write command
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      sec_r  <= fwpg_pkg::SEC_RST;
      tb_r   <= fwpg_pkg::TB_RST;
      bp_r   <= fwpg_pkg::BP_RST;
      cmp_r  <= fwpg_pkg::CMP_RST;
      mode_r <= fwpg_pkg::MODE_RST;
    end else if (clk_en) begin
      if (sr1_wr) begin
        sec_r     <= dat1_r[fwpg_pkg::SR1_SEC];
        tb_r      <= dat1_r[fwpg_pkg::SR1_TB];
        bp_r      <= dat1_r[fwpg_pkg::SR1_BP_LSB +: 3];
        mode_r[0] <= dat1_r[fwpg_pkg::SR1_MODE_LO];
      end
      if (sr2_wr) begin
        cmp_r     <= sr2_byte[fwpg_pkg::SR2_CMP];
        mode_r[1] <= sr2_byte[fwpg_pkg::SR2_MODE_HI];
      end
      if (soft_rst && mode_r == fwpg_pkg::MODE_LOCK) begin
        mode_r <= fwpg_pkg::MODE_SW;
      end
    end
  end

  // one-time mode has no exit short of supply reset: a status write could leave it,
  // but sr_open is low there

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire [7:0] sr1_img = {mode_r[0], sec_r, tb_r, bp_r, wen_r, busy_r};
  wire [7:0] sr2_img = {1'b0, cmp_r, 5'h00, mode_r[1]};
  wire [7:0] st_img  = {4'h0, rej_r, busy_r, puw_w, sleep_r};
  wire [7:0] rd_mux  =
    (reg_addr == fwpg_pkg::REG_SR1)   ? sr1_img :
    (reg_addr == fwpg_pkg::REG_SR2)   ? sr2_img :
    (reg_addr == fwpg_pkg::REG_STATE) ? st_img  : 8'h00;
  wire [7:0] rdata_nxt = reg_rd ? rd_mux : 8'h00;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire acc_w = arr_ok | sr_ok;

  always_ff @(posedge sys_clk or negedge sys_rst_b_r) begin
    if (!sys_rst_b_r) begin
      reg_rdata          <= 8'h00;
      cmd_accept         <= 1'b0;
      cmd_reject         <= 1'b0;
      cmd_opcode         <= 8'h00;
      cmd_addr           <= 24'h000000;
      write_enable_latch <= 1'b0;
      deep_sleep_state   <= 1'b0;
    end else if (clk_en) begin
      reg_rdata          <= rdata_nxt;
      cmd_accept         <= acc_w;
      cmd_reject         <= rej_w;
      write_enable_latch <= wen_nxt;
      deep_sleep_state   <= nap_w | (sleep_r & ~wake_w);
      if (acc_w) begin
        cmd_opcode <= op_r;
        cmd_addr   <= addr_r;
      end
    end
  end

endmodule : fwpg_gate

// file: src/fwpg_pkg.sv
// constants shared by the flash write-protect gate
package fwpg_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 200;
  // power-up write lockout, value is a plain default
  localparam int PUW_TIME_NS = 10000;
  localparam int PUW_CYCLES  = (PUW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] PUW_LAST = 12'(PUW_CYCLES);

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hD8;
  localparam logic [7:0] OP_CE_A  = 8'hC7;
  localparam logic [7:0] OP_CE_B  = 8'h60;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE  = 8'hAB;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST   = 8'h99;

  // ----------------------------------------------------------------
  // status bit positions and reset values
  // ----------------------------------------------------------------
  localparam int SR1_MODE_LO = 7;
  localparam int SR1_SEC     = 6;
  localparam int SR1_TB      = 5;
  localparam int SR1_BP_LSB  = 2;
  localparam int SR1_LATCH   = 1;
  localparam int SR1_BUSY    = 0;
  localparam int SR2_CMP     = 6;
  localparam int SR2_MODE_HI = 0;
  localparam logic       SEC_RST  = 1'b0;
  localparam logic       TB_RST   = 1'b0;
  localparam logic [2:0] BP_RST   = 3'h0;
  localparam logic       CMP_RST  = 1'b0;
  localparam logic [1:0] MODE_RST = 2'h0;

  localparam logic [1:0] MODE_SW   = 2'h0;
  localparam logic [1:0] MODE_HW   = 2'h1;
  localparam logic [1:0] MODE_LOCK = 2'h2;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_SR1   = 4'h0;
  localparam logic [3:0] REG_SR2   = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h8;
  localparam logic [3:0] REG_CTRL  = 4'hC;
  localparam int ST_SLEEP = 0;
  localparam int ST_PUW   = 1;
  localparam int ST_BUSY  = 2;
  localparam int ST_REJ   = 3;
  localparam int CTRL_DONE = 0;

  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_SHIFT = 2'b01,
    FR_EVAL  = 2'b11
  } fwpg_frame_t;

endpackage : fwpg_pkg

// file: src/fwpg_prot_if.sv
// carrier between the gate and its protected-range decoder
`timescale 1ns/100ps
interface fwpg_prot_if;
  logic        sec;
  logic        tb;
  logic        cmp;
  logic [2:0]  bp;
  logic [19:0] tgt_lo;
  logic [19:0] tgt_hi;
  logic        hit;
  modport req (output sec, tb, cmp, bp, tgt_lo, tgt_hi, input hit);
  modport dec (input sec, tb, cmp, bp, tgt_lo, tgt_hi, output hit);
endinterface : fwpg_prot_if

// file: src/fwpg_range_dec.sv
// protected address range decoder and overlap test
`timescale 1ns/100ps
module fwpg_range_dec (
  fwpg_prot_if.dec p
);

  // ----------------------------------------------------------------
  // base region with complement clear
  // ----------------------------------------------------------------
  wire        none_w = (p.bp == 3'h0);
  wire        all_w  = (p.bp[2:1] == 2'h3) |
                       (~p.sec & (p.bp == 3'h5));
  // sector sizes 4/8/16/32 kB, 10x both give 32 kB
  wire [1:0]  sec_sh = p.bp[2] ? 2'h3 : 2'(p.bp[1:0] - 2'h1);
  // block counts 1/2/4/8 of 64 kB
  wire [1:0]  blk_sh = 2'(p.bp - 3'h1);
  wire [19:0] size_w = p.sec ? (20'h01000 << sec_sh)
                             : (20'h10000 << blk_sh);
  // top/bottom picks the end the region grows from
  wire [19:0] lo_w = (all_w | p.tb) ? 20'h0 : 20'h0 - size_w;
  wire [19:0] hi_w = (all_w | ~p.tb) ? 20'hFFFFF
                                     : size_w - 20'h1;

  // ----------------------------------------------------------------
  // overlap test
  // ----------------------------------------------------------------
  wire meets_w  = (p.tgt_lo <= hi_w) & (p.tgt_hi >= lo_w);
  wire inside_w = (p.tgt_lo >= lo_w) & (p.tgt_hi <= hi_w);
  wire hit_pl_w = ~none_w & meets_w;
  // complement: protected is whatever the base leaves open
  wire hit_cm_w = none_w | (~all_w & ~inside_w);

  assign p.hit = p.cmp ? hit_cm_w : hit_pl_w;

endmodule : fwpg_range_dec
